/* File: pkg/t16_pkg.sv */
package t16_pkg;

  // register byte offsets on the 8-bit register bus
  localparam logic [3:0] T16_OFF_CTRL_A = 4'h0;
  localparam logic [3:0] T16_OFF_CTRL_B = 4'h1;
  localparam logic [3:0] T16_OFF_FLAGS = 4'h2;
  localparam logic [3:0] T16_OFF_MASK = 4'h3;
  localparam logic [3:0] T16_OFF_CNT_LO = 4'h4;
  localparam logic [3:0] T16_OFF_CNT_HI = 4'h5;
  localparam logic [3:0] T16_OFF_CAP_LO = 4'h6;
  localparam logic [3:0] T16_OFF_CAP_HI = 4'h7;
  localparam logic [3:0] T16_OFF_CMPA_LO = 4'h8;
  localparam logic [3:0] T16_OFF_CMPA_HI = 4'h9;
  localparam logic [3:0] T16_OFF_CMPB_LO = 4'hA;
  localparam logic [3:0] T16_OFF_CMPB_HI = 4'hB;
  localparam logic [3:0] T16_OFF_POWER = 4'hC;

  // flag and mask bit positions
  localparam int T16_FLG_OVF = 0;
  localparam int T16_FLG_CMPA = 1;
  localparam int T16_FLG_CMPB = 2;
  localparam int T16_FLG_CAP = 5;
  localparam logic [7:0] T16_FLG_IMPL = 8'h27;

  localparam logic [15:0] T16_BOTTOM = 16'h0000;
  localparam logic [15:0] T16_MAX = 16'hFFFF;
  localparam logic [15:0] T16_TOP8 = 16'h00FF;
  localparam logic [15:0] T16_TOP9 = 16'h01FF;
  localparam logic [15:0] T16_TOP10 = 16'h03FF;
  localparam logic [15:0] T16_ZERO16 = 16'h0000;
  localparam logic [7:0] T16_ZERO8 = 8'h00;
  localparam logic T16_PWR_OFF_RST = 1'h1;

  // prescaler taps: a tick fires when the masked prescaler bits are all ones
  localparam int T16_PRE_W = 10;
  localparam logic [9:0] T16_DIV8 = 10'h007;
  localparam logic [9:0] T16_DIV64 = 10'h03F;
  localparam logic [9:0] T16_DIV256 = 10'h0FF;
  localparam logic [9:0] T16_DIV1024 = 10'h3FF;

  typedef enum logic [2:0] {
    T16_CS_STOP = 3'h0, T16_CS_DIV1 = 3'h1, T16_CS_DIV8 = 3'h2, T16_CS_DIV64 = 3'h3,
    T16_CS_DIV256 = 3'h4, T16_CS_DIV1024 = 3'h5, T16_CS_EXT_FALL = 3'h6, T16_CS_EXT_RISE = 3'h7
  } t16_clksel_t;

  localparam logic [1:0] T16_COM_OFF = 2'h0;
  localparam logic [1:0] T16_COM_TOGGLE = 2'h1;
  localparam logic [1:0] T16_COM_CLEAR = 2'h2;
  localparam logic [1:0] T16_COM_SET = 2'h3;

  typedef enum logic [2:0] {
    T16_TOP_MAX, T16_TOP_8, T16_TOP_9, T16_TOP_10, T16_TOP_CMPA, T16_TOP_CAP
  } t16_topsel_t;

  typedef enum logic [1:0] {T16_BUS_IDLE = 2'b00, T16_BUS_DONE = 2'b01} t16_bus_st_t;

  typedef struct packed {
    logic [1:0] out_mode_a;
    logic [1:0] out_mode_b;
    logic [1:0] rsv;
    logic [1:0] wave_lo;
  } t16_ctrl_a_t;

  typedef struct packed {
    logic noise_en;
    logic edge_rise;
    logic use_comp;
    logic [1:0] wave_hi;
    t16_clksel_t clk_sel;
  } t16_ctrl_b_t;

  typedef struct packed {
    t16_topsel_t topsel;
    logic pwm;
    logic dual;
  } t16_mode_t;

  typedef struct packed {
    logic read;
    logic write;
    logic [3:0] address;
    logic [7:0] writedata;
  } t16_av_req_t;

  function automatic t16_mode_t t16_decode(input logic [3:0] wave);
    t16_mode_t m;
    m = '{T16_TOP_MAX, 1'b0, 1'b0};
    case (wave)
      4'h1: m = '{T16_TOP_8, 1'b1, 1'b1};
      4'h2: m = '{T16_TOP_9, 1'b1, 1'b1};
      4'h3: m = '{T16_TOP_10, 1'b1, 1'b1};
      4'h4: m = '{T16_TOP_CMPA, 1'b0, 1'b0};
      4'h5: m = '{T16_TOP_8, 1'b1, 1'b0};
      4'h6: m = '{T16_TOP_9, 1'b1, 1'b0};
      4'h7: m = '{T16_TOP_10, 1'b1, 1'b0};
      4'h8, 4'hA: m = '{T16_TOP_CAP, 1'b1, 1'b1};
      4'h9, 4'hB: m = '{T16_TOP_CMPA, 1'b1, 1'b1};
      4'hC: m = '{T16_TOP_CAP, 1'b0, 1'b0};
      4'hE: m = '{T16_TOP_CAP, 1'b1, 1'b0};
      4'hF: m = '{T16_TOP_CMPA, 1'b1, 1'b0};
      default: m = '{T16_TOP_MAX, 1'b0, 1'b0};
    endcase
    return m;
  endfunction

endpackage

/* File: design/t16_sync.sv */
`timescale 1ns/1ps
module t16_sync #(
  parameter int WIDTH = 2
) (
  input wire logic clk, // system clock
  input wire logic reset_n, // async reset
  input wire logic [WIDTH-1:0] d, // asynchronous inputs
  output logic [WIDTH-1:0] q // synchronised outputs
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } t16_sync_st_t;

  t16_sync_st_t st_r;
  t16_sync_st_t st_nxt;

  if (WIDTH < 1) begin : g_bad_width
    $error("t16_sync: WIDTH must be at least 1");
  end

  // the first stage feeds only the second stage
  always_comb begin
    st_nxt.s1 = d;
    st_nxt.s2 = st_r.s1;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q = st_r.s2;
endmodule

/* File: design/t16_filter.sv */
`timescale 1ns/1ps
module t16_filter #(
  parameter int LEN = 4
) (
  input wire logic clk, // system clock
  input wire logic reset_n, // async reset
  input wire logic en, // filter enable
  input wire logic d, // synchronised capture source
  output logic q // filtered level
);
  typedef struct packed {
    logic [LEN-1:0] hist;
    logic q;
  } t16_filt_st_t;

  t16_filt_st_t st_r;
  t16_filt_st_t st_nxt;

  if (LEN < 2 || LEN > 16) begin : g_bad_len
    $error("t16_filter: LEN must be 2 to 16");
  end

  // a level change passes only after LEN equal samples; costs LEN cycles of latency
  always_comb begin
    st_nxt = st_r;
    st_nxt.hist = {st_r.hist[LEN-2:0], d};
    if (!en) begin
      st_nxt.q = d;
    end else if (&st_r.hist) begin
      st_nxt.q = 1'b1;
    end else if (~|st_r.hist) begin
      st_nxt.q = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q = st_r.q;
endmodule

/* File: design/t16_timer_core.sv */
// Behaviour
// - one 8-bit high-byte holding register shared by all four 16-bit registers
// - low-byte write loads holding byte and written byte together in one cycle
// - count or capture low-byte read copies the register's high byte into the holding register
// - compare registers read both bytes directly, holding register untouched
// - bottom is signalled when the count equals zero
// - maximum is all ones and is signalled when the count reaches it
// - top comes from a fixed value, compare A or capture, per mode
// - compare A as PWM top drives no PWM output and is double buffered
// - capture register may hold a fixed top, leaving compare A free
// - both compare registers are compared with the count on every tick
// - each compare match sets its own compare match flag
// - compare results drive a waveform on each compare output pin
// - clock select picks prescaler or external pin edge; none selected means idle
// - capture pin or comparator edge copies the count into capture register
// - a digital noise filter guards the capture input against spikes
// - all requests show as flags and each is masked individually
// - 8-bit control registers are read and written directly
// - a software count write beats any clear or count in that cycle
// - the count is accessible whether or not a tick is present
`timescale 1ns/1ps
module t16_timer_core
  import t16_pkg::*;
#(
  parameter int FILTER_LEN = 4
) (
  input wire logic clk, // system clock, 25 MHz
  input wire logic reset_n, // async reset, active low
  input wire t16_av_req_t av_req, // avalon read, write, address, writedata
  output logic [7:0] av_readdata, // avalon read data
  output logic av_waitrequest, // avalon wait request
  input wire logic capture_input_pin, // capture pin, asynchronous
  input wire logic comparator_in, // analog comparator output, asynchronous
  input wire logic external_count_pin, // external count pin, asynchronous
  output logic [1:0] compare_output_pin, // waveform outputs, b in bit 1
  output logic [1:0] compare_output_oe, // waveform output enables
  output logic [7:0] timer_irq_req, // masked interrupt requests
  output logic at_bottom, // count is zero
  output logic at_max, // count is all ones
  output logic at_top // count equals the current top
);

  typedef struct packed {
    t16_bus_st_t bus;
    logic [7:0] rdata;
    logic [7:0] temp;
    logic [15:0] cnt;
    logic down;
    logic [1:0][15:0] cmp_buf;
    logic [1:0][15:0] cmp_act;
    logic [15:0] cap;
    t16_ctrl_a_t ctrl_a;
    t16_ctrl_b_t ctrl_b;
    logic [7:0] flags;
    logic [7:0] mask;
    logic pwr_off;
    logic [T16_PRE_W-1:0] pre;
    logic ext_q;
    logic cap_q;
    logic [1:0] wave;
  } t16_core_st_t;

  t16_core_st_t st_r;
  t16_core_st_t st_nxt;

  if (FILTER_LEN < 2 || FILTER_LEN > 16) begin : g_bad_filter_len
    $error("t16_timer_core: FILTER_LEN must be 2 to 16");
  end

  logic [2:0] sync_q;
  logic cap_src;
  logic cap_filt;

  t16_mode_t mode;
  logic [15:0] top_val;
  logic tick;

  logic rd_take;
  logic wr_take;
  logic [1:0] match;
  logic [1:0] pwm_ok;

  t16_sync #(
    .WIDTH(3)
  ) u_sync (
    .clk(clk),
    .reset_n(reset_n),
    .d({external_count_pin, comparator_in, capture_input_pin}),
    .q(sync_q)
  );

  // a source switch while the inputs differ looks like an edge
  assign cap_src = st_r.ctrl_b.use_comp ? sync_q[1] : sync_q[0];

  t16_filter #(
    .LEN(FILTER_LEN)
  ) u_filter (
    .clk(clk),
    .reset_n(reset_n),
    .en(st_r.ctrl_b.noise_en),
    .d(cap_src),
    .q(cap_filt)
  );

  assign mode = t16_decode({st_r.ctrl_b.wave_hi, st_r.ctrl_a.wave_lo});

  // compare A top is the active copy, so in pwm modes a change lands at top
  always_comb begin
    case (mode.topsel)
      T16_TOP_8: top_val = T16_TOP8;
      T16_TOP_9: top_val = T16_TOP9;
      T16_TOP_10: top_val = T16_TOP10;
      T16_TOP_CMPA: top_val = st_r.cmp_act[0];
      T16_TOP_CAP: top_val = st_r.cap;
      default: top_val = T16_MAX;
    endcase
  end

  always_comb begin
    // edges come from the synchronised pin, so they lag it
    case (st_r.ctrl_b.clk_sel)
      T16_CS_DIV1: tick = 1'b1;
      T16_CS_DIV8: tick = &(st_r.pre | ~T16_DIV8);
      T16_CS_DIV64: tick = &(st_r.pre | ~T16_DIV64);
      T16_CS_DIV256: tick = &(st_r.pre | ~T16_DIV256);
      T16_CS_DIV1024: tick = &(st_r.pre | ~T16_DIV1024);
      T16_CS_EXT_FALL: tick = st_r.ext_q & ~sync_q[2];
      T16_CS_EXT_RISE: tick = ~st_r.ext_q & sync_q[2];
      default: tick = 1'b0;
    endcase
    // no tick while powered off
    tick = tick & ~st_r.pwr_off;
  end

  // a request is answered one cycle after it appears; reads act on the first edge
  assign av_waitrequest = (av_req.read | av_req.write) & (st_r.bus == T16_BUS_IDLE);
  assign rd_take = av_req.read & (st_r.bus == T16_BUS_IDLE);
  assign wr_take = av_req.write & (st_r.bus == T16_BUS_DONE);

  // compare A has no PWM output while it sets the PWM top
  for (genvar i = 0; i < 2; i++) begin : g_cmp
    assign match[i] = tick & (st_r.cnt == st_r.cmp_act[i]);
    assign pwm_ok[i] = !(i == 0 && mode.pwm && mode.topsel == T16_TOP_CMPA);
    assign compare_output_oe[i] = (i == 0 ? st_r.ctrl_a.out_mode_a : st_r.ctrl_a.out_mode_b) != T16_COM_OFF
                                  && (pwm_ok[i] || (i == 0 ? st_r.ctrl_a.out_mode_a : st_r.ctrl_a.out_mode_b)
                                      == T16_COM_TOGGLE);
  end

  always_comb begin
    logic [1:0] com;
    logic at_top_tick;
    logic cap_evt;
    logic [7:0] clr;
    logic [7:0] set;

    com = T16_COM_OFF;
    at_top_tick = tick & (st_r.cnt == top_val);
    cap_evt = 1'b0;
    clr = T16_ZERO8;
    set = T16_ZERO8;

    st_nxt = st_r;
    // held at zero while off, so the first tick is a full period away
    st_nxt.pre = st_r.pwr_off ? '0 : st_r.pre + 1'b1;
    st_nxt.ext_q = sync_q[2];
    st_nxt.cap_q = cap_filt;

    // bus handshake
    // writes land on the edge where the master sees waitrequest low
    case (st_r.bus)
      T16_BUS_IDLE: begin
        if (av_req.read | av_req.write) begin
          st_nxt.bus = T16_BUS_DONE;
        end
      end
      T16_BUS_DONE: st_nxt.bus = T16_BUS_IDLE;
      default: st_nxt.bus = T16_BUS_IDLE;
    endcase

    // counting sequence
    // a bus write below overrides the counting sequence
    if (tick) begin
      if (mode.dual) begin
        if (!st_r.down) begin
          if (st_r.cnt >= top_val) begin
            st_nxt.down = 1'b1;
            st_nxt.cnt = st_r.cnt - 1'b1;
          end else begin
            st_nxt.cnt = st_r.cnt + 1'b1;
          end
        end else if (st_r.cnt == T16_BOTTOM) begin
          st_nxt.down = 1'b0;
          st_nxt.cnt = st_r.cnt + 1'b1;
          set[T16_FLG_OVF] = 1'b1;
        end else begin
          st_nxt.cnt = st_r.cnt - 1'b1;
        end
      end else begin
        st_nxt.down = 1'b0;
        if (at_top_tick && mode.topsel != T16_TOP_MAX) begin
          st_nxt.cnt = T16_BOTTOM;
        end else begin
          st_nxt.cnt = st_r.cnt + 1'b1;
        end
        if (mode.pwm ? at_top_tick : st_r.cnt == T16_MAX) begin
          set[T16_FLG_OVF] = 1'b1;
        end
      end
      // double-buffered compare values move to the active copy at top
      if (mode.pwm && at_top_tick) begin
        st_nxt.cmp_act = st_r.cmp_buf;
      end
    end

    // waveform generation per compare unit
    for (int i = 0; i < 2; i++) begin
      com = (i == 0) ? st_r.ctrl_a.out_mode_a : st_r.ctrl_a.out_mode_b;
      if (match[i]) begin
        set[i == 0 ? T16_FLG_CMPA : T16_FLG_CMPB] = 1'b1;
      end
      if (com == T16_COM_OFF || (!pwm_ok[i] && com != T16_COM_TOGGLE)) begin
        st_nxt.wave[i] = 1'b0;
      end else if (!mode.pwm || com == T16_COM_TOGGLE) begin
        if (match[i]) begin
          case (com)
            T16_COM_TOGGLE: st_nxt.wave[i] = ~st_r.wave[i];
            T16_COM_CLEAR: st_nxt.wave[i] = 1'b0;
            default: st_nxt.wave[i] = 1'b1;
          endcase
        end
      end else if (mode.dual) begin
        // dual slope: the level follows the direction
        if (match[i]) begin
          st_nxt.wave[i] = (com == T16_COM_SET) ^ st_r.down;
        end
      end else begin
        // fast pwm: match sets one level, top the other
        if (match[i]) begin
          st_nxt.wave[i] = (com == T16_COM_SET);
        end else if (at_top_tick) begin
          st_nxt.wave[i] = (com != T16_COM_SET);
        end
      end
    end

    // input capture is off while the capture register holds top
    // a capture low write in the same cycle wins over the event
    if (!st_r.pwr_off && mode.topsel != T16_TOP_CAP) begin
      cap_evt = st_r.ctrl_b.edge_rise ? (cap_filt & ~st_r.cap_q) : (~cap_filt & st_r.cap_q);
    end
    if (cap_evt) begin
      st_nxt.cap = st_r.cnt;
      set[T16_FLG_CAP] = 1'b1;
    end

    // register reads; the data register is loaded on the first edge
    // compare reads leave the holding byte alone
    if (rd_take) begin
      st_nxt.rdata = T16_ZERO8;
      case (av_req.address)
        T16_OFF_CTRL_A: st_nxt.rdata = st_r.ctrl_a;
        T16_OFF_CTRL_B: st_nxt.rdata = st_r.ctrl_b;
        T16_OFF_FLAGS: st_nxt.rdata = st_r.flags;
        T16_OFF_MASK: st_nxt.rdata = st_r.mask;
        T16_OFF_POWER: st_nxt.rdata = {7'h00, st_r.pwr_off};
        T16_OFF_CNT_LO: begin
          st_nxt.rdata = st_r.cnt[7:0];
          st_nxt.temp = st_r.cnt[15:8];
        end
        T16_OFF_CAP_LO: begin
          st_nxt.rdata = st_r.cap[7:0];
          st_nxt.temp = st_r.cap[15:8];
        end
        T16_OFF_CNT_HI, T16_OFF_CAP_HI: st_nxt.rdata = st_r.temp;
        T16_OFF_CMPA_LO: st_nxt.rdata = st_r.cmp_buf[0][7:0];
        T16_OFF_CMPA_HI: st_nxt.rdata = st_r.cmp_buf[0][15:8];
        T16_OFF_CMPB_LO: st_nxt.rdata = st_r.cmp_buf[1][7:0];
        T16_OFF_CMPB_HI: st_nxt.rdata = st_r.cmp_buf[1][15:8];
        default: st_nxt.rdata = T16_ZERO8;
      endcase
    end

    // register writes take effect on the edge that completes the request
    if (wr_take) begin
      case (av_req.address)
        T16_OFF_CTRL_A: st_nxt.ctrl_a = av_req.writedata;
        T16_OFF_CTRL_B: st_nxt.ctrl_b = av_req.writedata;
        T16_OFF_FLAGS: clr = av_req.writedata & T16_FLG_IMPL;
        T16_OFF_MASK: st_nxt.mask = av_req.writedata & T16_FLG_IMPL;
        T16_OFF_POWER: st_nxt.pwr_off = av_req.writedata[0];
        T16_OFF_CNT_HI, T16_OFF_CAP_HI, T16_OFF_CMPA_HI, T16_OFF_CMPB_HI: begin
          st_nxt.temp = av_req.writedata;
        end
        T16_OFF_CNT_LO: begin
          // writing a running count may skip a match
          st_nxt.cnt = {st_r.temp, av_req.writedata};
        end
        T16_OFF_CAP_LO: st_nxt.cap = {st_r.temp, av_req.writedata};
        T16_OFF_CMPA_LO, T16_OFF_CMPB_LO: begin
          for (int i = 0; i < 2; i++) begin
            if (av_req.address == (i == 0 ? T16_OFF_CMPA_LO : T16_OFF_CMPB_LO)) begin
              st_nxt.cmp_buf[i] = {st_r.temp, av_req.writedata};
              // outside pwm modes the active copy follows at once
              if (!mode.pwm) begin
                st_nxt.cmp_act[i] = {st_r.temp, av_req.writedata};
              end
            end
          end
        end
        default: clr = T16_ZERO8;
      endcase
    end

    // a hardware set in the clearing cycle wins over the write-one clear
    st_nxt.flags = ((st_r.flags & ~clr) | set) & T16_FLG_IMPL;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= '0;
      st_r.bus <= T16_BUS_IDLE;
      st_r.pwr_off <= T16_PWR_OFF_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign av_readdata = st_r.rdata;
  assign compare_output_pin = st_r.wave & compare_output_oe;
  assign timer_irq_req = st_r.flags & st_r.mask;

  // status outputs decode the registered count
  assign at_bottom = (st_r.cnt == T16_BOTTOM);
  assign at_max = (st_r.cnt == T16_MAX);
  assign at_top = (st_r.cnt == top_val);

endmodule

/* File: testbench/t16_timer_core_chk.sv */
`timescale 1ns/1ps
module t16_timer_core_chk
  import t16_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic reset_n, // async reset
  input wire t16_av_req_t av_req, // bus request
  input wire logic [7:0] av_readdata, // read data
  input wire logic av_waitrequest, // wait request
  input wire logic [1:0] compare_output_pin, // waveforms
  input wire logic [1:0] compare_output_oe, // pin enables
  input wire logic [7:0] timer_irq_req, // masked requests
  input wire logic at_bottom, // count zero
  input wire logic at_max // count all ones
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic [7:0] hold_r;
  logic known_r;
  logic wdone;
  assign wdone = av_req.write & ~av_waitrequest;
  // mirror of the shared high byte; a count or capture low read reloads it from that register, so it is then unknown
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hold_r <= 8'h00;
      known_r <= 1'b1;
    end else if (wdone && av_req.address[0] && av_req.address >= T16_OFF_CNT_HI && av_req.address <= T16_OFF_CMPB_HI) begin
      hold_r <= av_req.writedata;
      known_r <= 1'b1;
    end else if (av_req.read && (av_req.address == T16_OFF_CNT_LO || av_req.address == T16_OFF_CAP_LO)) begin
      known_r <= 1'b0;
    end
  end
  property p_wait;
    (av_req.read || av_req.write) && av_waitrequest |=> !av_waitrequest;
  endproperty
  a_wait: assert property (p_wait) else $error("bus answer late");
  property p_rdhold;
    !av_req.read |=> $stable(av_readdata);
  endproperty
  a_rdhold: assert property (p_rdhold) else $error("read data moved");
  property p_impl;
    (timer_irq_req & ~T16_FLG_IMPL) == 8'h00;
  endproperty
  a_impl: assert property (p_impl) else $error("reserved request bit set");
  property p_mask;
    wdone && av_req.address == T16_OFF_MASK && av_req.writedata == 8'h00 |-> ##2 timer_irq_req == 8'h00;
  endproperty
  a_mask: assert property (p_mask) else $error("masked request still out");
  logic [7:0] ctla_r;
  logic [7:0] ctlb_r;
  // control mirror; with compare A as a pwm top only toggle mode may drive pin A
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctla_r <= 8'h00;
      ctlb_r <= 8'h00;
    end else if (wdone && av_req.address == T16_OFF_CTRL_A) begin
      ctla_r <= av_req.writedata;
    end else if (wdone && av_req.address == T16_OFF_CTRL_B) begin
      ctlb_r <= av_req.writedata;
    end
  end
  property p_oe;
    {ctlb_r[4:3], ctla_r[1:0]} inside {4'h9, 4'hB, 4'hF} && ctla_r[7:6] != T16_COM_TOGGLE
      |-> compare_output_oe[0] == 1'b0 && compare_output_pin[0] == 1'b0;
  endproperty
  a_oe: assert property (p_oe) else $error("compare A drives its pin while it is top");
  property p_bot;
    wdone && known_r && av_req.address == T16_OFF_CNT_LO && {hold_r, av_req.writedata} == T16_BOTTOM |=> at_bottom;
  endproperty
  a_bot: assert property (p_bot) else $error("zero count not at bottom");
  property p_max;
    wdone && known_r && av_req.address == T16_OFF_CNT_LO && {hold_r, av_req.writedata} == T16_MAX |=> at_max;
  endproperty
  a_max: assert property (p_max) else $error("all ones count not at max");
  property p_rst;
    $rose(reset_n) |-> at_bottom && timer_irq_req == 8'h00;
  endproperty
  a_rst: assert property (p_rst) else $error("count not cleared by reset");
endmodule
bind t16_timer_core t16_timer_core_chk i_chk (.clk(clk), .reset_n(reset_n), .av_req(av_req),
  .av_readdata(av_readdata), .av_waitrequest(av_waitrequest), .compare_output_pin(compare_output_pin),
  .compare_output_oe(compare_output_oe), .timer_irq_req(timer_irq_req), .at_bottom(at_bottom), .at_max(at_max));

/* File: testbench/t16_cpu_model.sv */
`timescale 1ns/1ps
module t16_cpu_model
  import t16_pkg::*;
(
  input wire logic clk, // system clock
  output t16_av_req_t av_req, // bus request
  input wire logic [7:0] av_readdata, // read data
  input wire logic av_waitrequest // wait request
);
  initial av_req = '0;
  // the iff samples the pre-edge answer, so request and data change only after the taking edge
  task automatic xfer(input logic w, input logic [3:0] a, input logic [7:0] d, output logic [7:0] q);
    av_req <= '{read: ~w, write: w, address: a, writedata: d};
    @(posedge clk iff (av_waitrequest === 1'b0));
    q = av_readdata;
    av_req <= '0;
    @(posedge clk);
  endtask
  task automatic wr8(input logic [3:0] a, input logic [7:0] d);
    logic [7:0] q;
    xfer(1'b1, a, d, q);
  endtask
  task automatic rd8(input logic [3:0] a, output logic [7:0] q);
    xfer(1'b0, a, 8'h00, q);
  endtask
  task automatic wr16(input logic [3:0] a, input logic [15:0] v);
    wr8(a + 4'h1, v[15:8]);
    wr8(a, v[7:0]);
  endtask
  task automatic rd16(input logic [3:0] a, output logic [15:0] v);
    rd8(a, v[7:0]);
    rd8(a + 4'h1, v[15:8]);
  endtask
  task automatic power_up;
    wr8(T16_OFF_POWER, 8'h00);
  endtask
endmodule

/* File: testbench/sixteen_bit_timer_core_tb_top.sv */
`timescale 1ns/1ps
module sixteen_bit_timer_core_tb_top;
  import t16_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [2:0] pins = 3'h0;
  t16_av_req_t av_req;
  logic [7:0] av_readdata;
  logic av_waitrequest;
  logic [1:0] compare_output_pin;
  logic [1:0] compare_output_oe;
  logic [7:0] timer_irq_req;
  logic at_bottom;
  logic at_max;
  logic at_top;
  int fails = 0;
  int checks = 0;
  int cycles = 0;
  always #20 clk = ~clk;
  t16_timer_core i_dut (.clk(clk), .reset_n(reset_n), .av_req(av_req), .av_readdata(av_readdata),
    .av_waitrequest(av_waitrequest), .capture_input_pin(pins[0]), .comparator_in(pins[1]),
    .external_count_pin(pins[2]), .compare_output_pin(compare_output_pin), .compare_output_oe(compare_output_oe),
    .timer_irq_req(timer_irq_req), .at_bottom(at_bottom), .at_max(at_max), .at_top(at_top));
  t16_cpu_model i_cpu (.clk(clk), .av_req(av_req), .av_readdata(av_readdata), .av_waitrequest(av_waitrequest));
  task automatic give_verdict;
    if (fails == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails = fails + 1;
      give_verdict();
    end
  end
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks = checks + 1;
    if (seen !== exp) begin
      fails = fails + 1;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // pulse long enough to pass the synchronisers, then let the pipeline drain
  task automatic pulse(input int sel, input int len);
    pins[sel] <= 1'b1;
    repeat (len) @(posedge clk);
    pins[sel] <= 1'b0;
    repeat (14) @(posedge clk);
  endtask
  task automatic t_reset;
    logic [15:0] v;
    logic [7:0] b;
    for (int i = 0; i < 4; i++) begin
      i_cpu.rd16(4'(4 + 2 * i), v);
      chk("reg16", v, 16'h0000);
    end
    i_cpu.rd8(T16_OFF_POWER, b);
    chk("power", 16'(b), 16'h0001);
    i_cpu.wr8(4'hD, 8'h5A);
    i_cpu.rd8(4'hD, b);
    chk("unmapped", 16'(b), 16'h0000);
    i_cpu.wr8(T16_OFF_CTRL_A, 8'h03);
    i_cpu.rd8(T16_OFF_CTRL_A, b);
    chk("ctrl_a", 16'(b), 16'h0003);
    i_cpu.wr8(T16_OFF_CTRL_A, 8'h00);
  endtask
  task automatic t_access;
    logic [15:0] v;
    logic [7:0] b;
    i_cpu.wr16(T16_OFF_CNT_LO, 16'hFFFF);
    chk("at_max", 16'(at_max), 16'h0001);
    i_cpu.wr16(T16_OFF_CNT_LO, 16'h01FF);
    repeat (20) @(posedge clk);
    i_cpu.rd16(T16_OFF_CNT_LO, v);
    chk("count", v, 16'h01FF);
    i_cpu.wr16(T16_OFF_CMPA_LO, 16'h1234);
    i_cpu.rd8(T16_OFF_CNT_LO, b);
    i_cpu.rd16(T16_OFF_CMPA_LO, v);
    chk("cmp_a", v, 16'h1234);
    i_cpu.rd8(T16_OFF_CNT_HI, b);
    chk("hold", 16'(b), 16'h0001);
    i_cpu.wr8(T16_OFF_CNT_HI, 8'hAB);
    i_cpu.wr8(T16_OFF_CMPB_LO, 8'hCD);
    i_cpu.rd16(T16_OFF_CMPB_LO, v);
    chk("cmp_b", v, 16'hABCD);
    i_cpu.rd16(T16_OFF_CNT_LO, v);
    chk("count", v, 16'h01FF);
  endtask
  task automatic t_count;
    logic [7:0] b;
    int n;
    i_cpu.power_up();
    i_cpu.wr8(T16_OFF_MASK, 8'h03);
    i_cpu.wr16(T16_OFF_CMPB_LO, 16'h0010);
    i_cpu.wr16(T16_OFF_CMPA_LO, 16'h0008);
    i_cpu.wr8(T16_OFF_CTRL_B, 8'h01);
    i_cpu.wr16(T16_OFF_CNT_LO, 16'hFFF0);
    n = 0;
    while (at_bottom !== 1'b1 && n < 60) begin
      @(posedge clk);
      n++;
    end
    chk("bottom", 16'(at_bottom), 16'h0001);
    repeat (40) @(posedge clk);
    i_cpu.rd8(T16_OFF_FLAGS, b);
    chk("flags", 16'(b), 16'h0007);
    chk("irq", 16'(timer_irq_req), 16'h0003);
    i_cpu.wr8(T16_OFF_CTRL_B, 8'h00);
    i_cpu.wr8(T16_OFF_FLAGS, 8'h27);
    i_cpu.rd8(T16_OFF_FLAGS, b);
    chk("flags", 16'(b), 16'h0000);
    i_cpu.wr8(T16_OFF_MASK, 8'h00);
  endtask
  task automatic t_capture;
    logic [15:0] v;
    logic [7:0] b;
    i_cpu.wr16(T16_OFF_CNT_LO, 16'h4321);
    i_cpu.wr8(T16_OFF_CTRL_B, 8'h40);
    pulse(0, 3);
    i_cpu.rd16(T16_OFF_CAP_LO, v);
    chk("cap_pin", v, 16'h4321);
    i_cpu.rd8(T16_OFF_FLAGS, b);
    chk("cap_flag", 16'(b), 16'h0020);
    i_cpu.wr16(T16_OFF_CNT_LO, 16'h0777);
    i_cpu.wr8(T16_OFF_CTRL_B, 8'h60);
    pulse(1, 3);
    i_cpu.rd16(T16_OFF_CAP_LO, v);
    chk("cap_cmp", v, 16'h0777);
    i_cpu.wr16(T16_OFF_CNT_LO, 16'h0999);
    i_cpu.wr8(T16_OFF_CTRL_B, 8'hC0);
    pulse(0, 2);
    i_cpu.rd16(T16_OFF_CAP_LO, v);
    chk("spike", v, 16'h0777);
    pulse(0, 10);
    i_cpu.rd16(T16_OFF_CAP_LO, v);
    chk("filtered", v, 16'h0999);
    i_cpu.wr8(T16_OFF_FLAGS, 8'h27);
  endtask
  task automatic t_ext;
    logic [15:0] v;
    for (int m = 6; m < 8; m++) begin
      i_cpu.wr16(T16_OFF_CNT_LO, 16'h0000);
      i_cpu.wr8(T16_OFF_CTRL_B, 8'(m));
      repeat (5) pulse(2, 4);
      i_cpu.wr8(T16_OFF_CTRL_B, 8'h00);
      i_cpu.rd16(T16_OFF_CNT_LO, v);
      chk("ext_count", v, 16'h0005);
    end
  endtask
  task automatic t_wave;
    i_cpu.wr8(T16_OFF_CTRL_A, 8'h50);
    chk("oe_toggle", 16'(compare_output_oe), 16'h0003);
    chk("pin_idle", 16'(compare_output_pin), 16'h0000);
    i_cpu.wr16(T16_OFF_CNT_LO, 16'h0000);
    i_cpu.wr8(T16_OFF_CTRL_B, 8'h01);
    repeat (30) @(posedge clk);
    i_cpu.wr8(T16_OFF_CTRL_B, 8'h00);
    chk("pin_toggled", 16'(compare_output_pin), 16'h0003);
    i_cpu.wr8(T16_OFF_CTRL_B, 8'h18);
    i_cpu.wr8(T16_OFF_CTRL_A, 8'hA3);
    chk("oe_top_a", 16'(compare_output_oe), 16'h0002);
    i_cpu.wr8(T16_OFF_CTRL_A, 8'hA2);
    chk("oe_top_cap", 16'(compare_output_oe), 16'h0003);
    i_cpu.wr16(T16_OFF_CAP_LO, 16'h0100);
    i_cpu.wr16(T16_OFF_CNT_LO, 16'h0100);
    chk("at_top", 16'(at_top), 16'h0001);
    i_cpu.wr8(T16_OFF_CTRL_A, 8'h00);
    i_cpu.wr8(T16_OFF_CTRL_B, 8'h00);
  endtask
  initial begin
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_access();
    t_count();
    t_capture();
    t_ext();
    t_wave();
    give_verdict();
  end
endmodule
